// *** hw/mcl_pkg.sv ***
package mcl_pkg;

	// ==========================================================
	// clock and timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
	localparam int DEBOUNCE_MS = 5;
	localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * 1_000_000 / CLK_PERIOD_NS;

	// ==========================================================
	// serial framing
	localparam int BAUD_MIN = 300;
	localparam int BAUD_MAX = 19200;
	localparam logic [2:0] BAUD_SEL_DEFAULT = 3'h5;
	localparam logic [2:0] BAUD_SEL_LAST = 3'h6;
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ODD = 2'h1;
	localparam logic [1:0] PAR_EVEN = 2'h2;
	localparam logic STOP_ONE = 1'b0;
	localparam logic STOP_TWO = 1'b1;
	localparam logic [7:0] ADDR_DEFAULT = 8'h01;
	localparam logic [7:0] CHAR_CR = 8'h0d;

	// ==========================================================
	// register offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_LOCK4 = 4'h1;
	localparam logic [3:0] OFS_SERCFG = 4'h2;
	localparam logic [3:0] OFS_ADDR = 4'h3;
	localparam logic [3:0] OFS_SP1 = 4'h4;
	localparam logic [3:0] OFS_SP2 = 4'h5;
	localparam logic [3:0] OFS_AL1 = 4'h6;
	localparam logic [3:0] OFS_AL2 = 4'h7;
	localparam logic [3:0] OFS_DISPLAY = 4'h8;
	localparam logic [3:0] OFS_PEAK = 4'h9;
	localparam logic [3:0] OFS_VALLEY = 4'ha;
	localparam logic [3:0] OFS_STATUS = 4'hb;
	localparam logic [3:0] OFS_SERDATA = 4'hc;
	localparam logic [3:0] OFS_TARE = 4'hd;

	// ==========================================================
	// field positions and reset values
	localparam int CTRL_RESET_SCOPE = 0;
	localparam int CTRL_PRINT_EN = 1;
	localparam int CTRL_ALARM_RST = 2;
	localparam int CTRL_ALARM_LATCH = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [4:0] LOCK4_RESET = 5'h1f;
	localparam int SER_PAR_LSB = 3;
	localparam int SER_STOP = 5;
	localparam int STAT_RXVALID = 8;

	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_BAUD = 3'b001,
		ST_PARITY = 3'b010,
		ST_STOP = 3'b011,
		ST_ADDR = 3'b100,
		ST_EXIT1 = 3'b101,
		ST_EXIT2 = 3'b110
	} mcl_menu_t;

	function automatic int baud_rate(input logic [2:0] sel);
		case (sel)
			3'h0: return BAUD_MIN;
			3'h1: return 600;
			3'h2: return 1200;
			3'h3: return 2400;
			3'h4: return 4800;
			3'h5: return 9600;
			default: return BAUD_MAX;
		endcase
	endfunction : baud_rate

endpackage : mcl_pkg

// *** hw/mcl_serial_port.sv ***
module mcl_serial_port #(
	parameter int DIV_W = 19
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [DIV_W-1:0] bitDiv,
	input wire logic [1:0] paritySelect,
	input wire logic stopBitSelect,
	input wire logic txGo,
	input wire logic [7:0] txByte,
	output logic txBusy,
	output logic txLine,
	input wire logic rxLine,
	output logic rxStrobe,
	output logic [7:0] rxByte
);

	// ==========================================================
	// frame layout
	wire parOn = (paritySelect != mcl_pkg::PAR_NONE);
	wire parOdd = (paritySelect == mcl_pkg::PAR_ODD);
	wire [3:0] txBits = 4'ha + {3'h0, parOn} + {3'h0, stopBitSelect};
	wire [3:0] rxBits = 4'ha + {3'h0, parOn};

	function automatic logic par_bit(input logic [7:0] d, input logic odd);
		return (^d) ^ odd;
	endfunction : par_bit

	// ==========================================================
	// transmitter
	logic [11:0] txSh_ff;
	logic [3:0] txCnt_ff;
	logic [DIV_W-1:0] txDiv_ff;
	wire [11:0] txFrame = parOn ? {2'b11, par_bit(txByte, parOdd), txByte, 1'b0}
		: {3'b111, txByte, 1'b0};
	wire txTick = (txDiv_ff == '0);

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			txSh_ff <= 12'hfff;
			txCnt_ff <= 4'h0;
			txDiv_ff <= '0;
		end
		else if (txCnt_ff == 4'h0)
		begin
			if (txGo)
			begin
				txSh_ff <= txFrame;
				txCnt_ff <= txBits;
				txDiv_ff <= bitDiv;
			end
		end
		else if (txTick)
		begin
			txSh_ff <= {1'b1, txSh_ff[11:1]};
			txCnt_ff <= txCnt_ff - 4'h1;
			txDiv_ff <= bitDiv;
		end
		else
			txDiv_ff <= txDiv_ff - 1'b1;
	end

	// idle frames shift in ones, so bit 0 is high between frames
	assign txLine = txSh_ff[0];
	assign txBusy = (txCnt_ff != 4'h0);

	// ==========================================================
	// receiver, samples mid bit
	logic [10:0] rxSh_ff;
	logic [3:0] rxCnt_ff;
	logic [DIV_W-1:0] rxDiv_ff;
	logic rxStb_ff;
	wire rxTick = (rxDiv_ff == '0);
	wire [10:0] rxNext = {rxLine, rxSh_ff[10:1]};
	// last sample is the stop bit; a low stop drops the byte
	wire rxLast = (rxCnt_ff == 4'h1) && rxLine;
	wire [7:0] rxData = parOn ? rxNext[8:1] : rxNext[9:2];

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rxSh_ff <= 11'h0;
			rxCnt_ff <= 4'h0;
			rxDiv_ff <= '0;
			rxStb_ff <= 1'b0;
			rxByte <= 8'h0;
		end
		else
		begin
			rxStb_ff <= 1'b0;
			if (rxCnt_ff == 4'h0)
			begin
				if (!rxLine)
				begin
					rxCnt_ff <= rxBits;
					rxDiv_ff <= bitDiv >> 1;
				end
			end
			else if (rxTick)
			begin
				rxSh_ff <= rxNext;
				rxCnt_ff <= rxCnt_ff - 4'h1;
				rxDiv_ff <= bitDiv;
				if (rxLast && !parOn)
				begin
					rxByte <= rxNext[9:2];
					rxStb_ff <= 1'b1;
				end
				else if (rxLast && (par_bit(rxData, parOdd) == rxNext[9]))
				begin
					rxByte <= rxData;
					rxStb_ff <= 1'b1;
				end
			end
			else
				rxDiv_ff <= rxDiv_ff - 1'b1;
		end
	end

	assign rxStrobe = rxStb_ff;

endmodule : mcl_serial_port

// *** hw/mcl_control_lines.sv ***
// Chosen here: the address-and-strobe port and the address map.
module mcl_control_lines #(
	parameter int CLK_HZ = mcl_pkg::CLK_HZ,
	parameter int DEBOUNCE_CYCLES = mcl_pkg::DEBOUNCE_CYCLES,
	parameter int RW = 20
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [31:0] regRdData,
	input wire logic signed [RW-1:0] liveReading,
	input wire logic readingStb,
	input wire logic zeroInN,
	input wire logic peakInN,
	input wire logic valleyInN,
	input wire logic resetInN,
	input wire logic holdInN,
	input wire logic lockoutInN,
	input wire logic printInN,
	input wire logic menuBtnN,
	input wire logic maxBtnN,
	input wire logic minBtnN,
	input wire logic resetBtnN,
	input wire logic serialRx,
	output logic serialTx,
	input wire logic [3:0] switchPinIn,
	output logic [3:0] switchPinOut,
	output logic [3:0] switchPinOe,
	output logic signed [RW-1:0] displayValue,
	output logic displayFlash,
	output logic hardResetIndication
);

	localparam int NIN = 11;
	localparam int DB_W = $clog2(DEBOUNCE_CYCLES + 1);
	localparam int DIV_W = $clog2(CLK_HZ / mcl_pkg::BAUD_MIN + 1);
	localparam int NHEX = RW / 4;

	if (RW % 4 != 0 || RW > 28 || DEBOUNCE_CYCLES < 1 || CLK_HZ < 16 * mcl_pkg::BAUD_MAX)
	begin : g_bad_param
		$error("mcl_control_lines: unsupported parameter value");
	end

	// ==========================================================
	// contact debounce
	wire [NIN-1:0] rawN = {resetBtnN, minBtnN, maxBtnN, menuBtnN, printInN, lockoutInN,
		holdInN, resetInN, valleyInN, peakInN, zeroInN};
	logic [NIN-1:0] act_ff;
	logic [NIN-1:0] actDly_ff;

	for (genvar i = 0; i < NIN; i++)
	begin : g_db
		logic [1:0] sync_ff;
		logic [DB_W-1:0] cnt_ff;
		always_ff @(posedge ref_clk or negedge resetn)
		begin
			if (!resetn)
			begin
				sync_ff <= 2'b11;
				cnt_ff <= '0;
				act_ff[i] <= 1'b0;
			end
			else
			begin
				sync_ff <= {sync_ff[0], rawN[i]};
				if (act_ff[i] == !sync_ff[1])
					cnt_ff <= '0;
				else if (cnt_ff == DB_W'(DEBOUNCE_CYCLES - 1))
				begin
					cnt_ff <= '0;
					act_ff[i] <= !sync_ff[1];
				end
				else
					cnt_ff <= cnt_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			actDly_ff <= '0;
		else
			actDly_ff <= act_ff;
	end

	wire [NIN-1:0] press = act_ff & ~actDly_ff;
	wire zeroPress = press[0];
	wire peakOn = act_ff[1];
	wire valleyOn = act_ff[2];
	wire resetPress = press[3];
	wire holdOn = act_ff[4];
	wire lockoutOn = act_ff[5];
	wire printPress = press[6];
	wire menuPress = press[7];
	wire maxPress = press[8];
	wire minPress = press[9];
	wire btnResetPress = press[10];

	// ==========================================================
	// configuration registers
	logic [3:0] ctrl_ff;
	logic [4:0] lockByteFour_ff;
	logic [2:0] baudSel_ff;
	logic [1:0] paritySelect_ff;
	logic stopBitSelect_ff;
	logic [7:0] busAddress_ff;
	logic signed [RW-1:0] limit_ff [4];
	mcl_pkg::mcl_menu_t menu_ff;
	logic [2:0] wBaud_ff;
	logic [1:0] wPar_ff;
	logic wStop_ff;
	logic [7:0] wAddr_ff;

	wire cfgWrOk = !lockoutOn;
	wire commUnlocked = (lockByteFour_ff == 5'h00);
	wire commWrOk = cfgWrOk && commUnlocked;
	wire wr = regWrStb && cfgWrOk;
	wire resetScopeSelect = ctrl_ff[mcl_pkg::CTRL_RESET_SCOPE];
	wire hardReset = resetPress && !resetScopeSelect;
	wire pvClear = resetPress;

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_ff <= mcl_pkg::CTRL_RESET;
			lockByteFour_ff <= mcl_pkg::LOCK4_RESET;
			for (int k = 0; k < 4; k++)
				limit_ff[k] <= '0;
		end
		else
		begin
			if (wr && regAddr == mcl_pkg::OFS_CTRL)
				ctrl_ff <= regWrData[3:0];
			if (wr && regAddr == mcl_pkg::OFS_LOCK4)
				lockByteFour_ff <= regWrData[4:0];
			for (int k = 0; k < 4; k++)
				if (wr && regAddr == mcl_pkg::OFS_SP1 + 4'(k))
					limit_ff[k] <= regWrData[RW-1:0];
		end
	end

	// ==========================================================
	// setup menu
	wire menuStore = menuPress && commWrOk;
	wire regSerWr = regWrStb && commWrOk && regAddr == mcl_pkg::OFS_SERCFG;
	wire regAddrWr = regWrStb && commWrOk && regAddr == mcl_pkg::OFS_ADDR;

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			menu_ff <= mcl_pkg::ST_RUN;
			baudSel_ff <= mcl_pkg::BAUD_SEL_DEFAULT;
			paritySelect_ff <= mcl_pkg::PAR_NONE;
			stopBitSelect_ff <= mcl_pkg::STOP_ONE;
			busAddress_ff <= mcl_pkg::ADDR_DEFAULT;
			wBaud_ff <= mcl_pkg::BAUD_SEL_DEFAULT;
			wPar_ff <= mcl_pkg::PAR_NONE;
			wStop_ff <= mcl_pkg::STOP_ONE;
			wAddr_ff <= mcl_pkg::ADDR_DEFAULT;
		end
		else if (hardReset)
			menu_ff <= mcl_pkg::ST_RUN;
		else
		begin
			if (regSerWr && regWrData[2:0] <= mcl_pkg::BAUD_SEL_LAST
				&& regWrData[4:3] != 2'h3)
			begin
				baudSel_ff <= regWrData[2:0];
				paritySelect_ff <= regWrData[4:3];
				stopBitSelect_ff <= regWrData[mcl_pkg::SER_STOP];
			end
			if (regAddrWr)
				busAddress_ff <= regWrData[7:0];
			unique case (menu_ff)
				mcl_pkg::ST_RUN:
					if (menuPress && !lockoutOn)
					begin
						menu_ff <= mcl_pkg::ST_BAUD;
						wBaud_ff <= baudSel_ff;
						wPar_ff <= paritySelect_ff;
						wStop_ff <= stopBitSelect_ff;
						wAddr_ff <= busAddress_ff;
					end
				mcl_pkg::ST_BAUD:
					if (maxPress)
						wBaud_ff <= (wBaud_ff == mcl_pkg::BAUD_SEL_LAST) ? 3'h0
							: wBaud_ff + 3'h1;
					else if (menuPress)
					begin
						if (menuStore)
							baudSel_ff <= wBaud_ff;
						menu_ff <= mcl_pkg::ST_PARITY;
					end
				mcl_pkg::ST_PARITY, mcl_pkg::ST_STOP:
					if (maxPress && menu_ff == mcl_pkg::ST_PARITY)
						wPar_ff <= (wPar_ff == mcl_pkg::PAR_EVEN) ? mcl_pkg::PAR_NONE
							: wPar_ff + 2'h1;
					else if (maxPress)
						wStop_ff <= !wStop_ff;
					else if (minPress)
						menu_ff <= (menu_ff == mcl_pkg::ST_PARITY) ? mcl_pkg::ST_STOP
							: mcl_pkg::ST_PARITY;
					else if (menuPress)
					begin
						if (menuStore)
						begin
							paritySelect_ff <= wPar_ff;
							stopBitSelect_ff <= wStop_ff;
						end
						menu_ff <= mcl_pkg::ST_ADDR;
					end
				mcl_pkg::ST_ADDR:
					if (maxPress)
						wAddr_ff <= wAddr_ff + 8'h01;
					else if (menuPress)
					begin
						if (menuStore)
							busAddress_ff <= wAddr_ff;
						menu_ff <= mcl_pkg::ST_EXIT1;
					end
				mcl_pkg::ST_EXIT1:
					if (btnResetPress)
						menu_ff <= mcl_pkg::ST_EXIT2;
				mcl_pkg::ST_EXIT2:
					if (btnResetPress)
						menu_ff <= mcl_pkg::ST_RUN;
				default:
					menu_ff <= mcl_pkg::ST_RUN;
			endcase
		end
	end

	// ==========================================================
	// reading path: tare, peak, valley, display
	logic signed [RW-1:0] tare_ff;
	logic signed [RW-1:0] highestReading_ff;
	logic signed [RW-1:0] lowestReading_ff;
	logic pvValid_ff;
	logic signed [RW-1:0] display_ff;
	logic flash_ff;
	logic hardInd_ff;
	wire signed [RW-1:0] netReading = liveReading - tare_ff;
	wire signed [RW-1:0] shownLive = peakOn ? highestReading_ff
		: valleyOn ? lowestReading_ff : netReading;

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tare_ff <= '0;
			highestReading_ff <= '0;
			lowestReading_ff <= '0;
			pvValid_ff <= 1'b0;
			display_ff <= '0;
			flash_ff <= 1'b0;
			hardInd_ff <= 1'b0;
		end
		else
		begin
			hardInd_ff <= hardReset;
			if (hardReset)
				tare_ff <= '0;
			else if (zeroPress)
				tare_ff <= liveReading;
			if (pvClear)
				pvValid_ff <= 1'b0;
			else if (readingStb)
			begin
				pvValid_ff <= 1'b1;
				if (!pvValid_ff || netReading > highestReading_ff)
					highestReading_ff <= netReading;
				if (!pvValid_ff || netReading < lowestReading_ff)
					lowestReading_ff <= netReading;
			end
			if (!holdOn)
				display_ff <= shownLive;
			flash_ff <= (peakOn || valleyOn) && !holdOn;
		end
	end

	// ==========================================================
	// setpoint and alarm switches
	logic [3:0] swOn_ff;
	logic [3:0] alarmHeld_ff;
	wire alarmReset = printPress && ctrl_ff[mcl_pkg::CTRL_ALARM_RST];
	wire [3:0] over;

	for (genvar j = 0; j < 4; j++)
	begin : g_cmp
		assign over[j] = (netReading >= limit_ff[j]);
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			swOn_ff <= 4'h0;
			alarmHeld_ff <= 4'h0;
		end
		else
		begin
			if (readingStb)
				swOn_ff <= {over[3:2] | alarmHeld_ff[3:2], over[1:0]};
			if (readingStb && ctrl_ff[mcl_pkg::CTRL_ALARM_LATCH])
				alarmHeld_ff <= alarmHeld_ff | {over[3:2], 2'b00};
			else if (alarmReset || hardReset)
				alarmHeld_ff <= 4'h0;
		end
	end

	// ==========================================================
	// serial: printout, host transmit, receive
	logic txGo_ff;
	logic [7:0] txByte_ff;
	logic [3:0] prtLeft_ff;
	logic signed [RW-1:0] prtVal_ff;
	logic hostPend_ff;
	logic [7:0] hostByte_ff;
	logic rxValid_ff;
	logic [7:0] rxHold_ff;
	wire txBusy;
	wire rxStrobe;
	wire [7:0] rxByte;
	wire txFree = !txBusy && !txGo_ff;
	wire [3:0] nib = prtVal_ff[RW-1 -: 4];
	wire [7:0] hexChar = (nib < 4'ha) ? {4'h3, nib} : {4'h4, nib - 4'h9};
	wire [DIV_W-1:0] bitDiv = DIV_W'(CLK_HZ / mcl_pkg::baud_rate(baudSel_ff) - 1);
	wire startPrint = printPress && ctrl_ff[mcl_pkg::CTRL_PRINT_EN] && prtLeft_ff == 4'h0;
	wire rdSer = regRdStb && regAddr == mcl_pkg::OFS_SERDATA;

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			txGo_ff <= 1'b0;
			txByte_ff <= 8'h00;
			prtLeft_ff <= 4'h0;
			prtVal_ff <= '0;
			hostPend_ff <= 1'b0;
			hostByte_ff <= 8'h00;
			rxValid_ff <= 1'b0;
			rxHold_ff <= 8'h00;
		end
		else
		begin
			txGo_ff <= 1'b0;
			if (regWrStb && regAddr == mcl_pkg::OFS_SERDATA && !hostPend_ff)
			begin
				hostPend_ff <= 1'b1;
				hostByte_ff <= regWrData[7:0];
			end
			if (startPrint)
			begin
				prtLeft_ff <= 4'(NHEX + 1);
				prtVal_ff <= display_ff;
			end
			else if (txFree && prtLeft_ff != 4'h0)
			begin
				txGo_ff <= 1'b1;
				txByte_ff <= (prtLeft_ff == 4'h1) ? mcl_pkg::CHAR_CR : hexChar;
				prtVal_ff <= prtVal_ff <<< 4;
				prtLeft_ff <= prtLeft_ff - 4'h1;
			end
			else if (txFree && hostPend_ff)
			begin
				txGo_ff <= 1'b1;
				txByte_ff <= hostByte_ff;
				hostPend_ff <= 1'b0;
			end
			if (rxStrobe)
			begin
				rxValid_ff <= 1'b1;
				rxHold_ff <= rxByte;
			end
			else if (rdSer)
				rxValid_ff <= 1'b0;
		end
	end

	mcl_serial_port #(
		.DIV_W(DIV_W)
	) u_serial (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.bitDiv(bitDiv),
		.paritySelect(paritySelect_ff),
		.stopBitSelect(stopBitSelect_ff),
		.txGo(txGo_ff),
		.txByte(txByte_ff),
		.txBusy(txBusy),
		.txLine(serialTx),
		.rxLine(serialRx),
		.rxStrobe(rxStrobe),
		.rxByte(rxByte)
	);

	// ==========================================================
	// register read port
	logic [31:0] rd_ff;
	wire [31:0] serCfg = {26'h0, stopBitSelect_ff, paritySelect_ff, baudSel_ff};
	wire [31:0] status = {19'h0, rxValid_ff, switchPinIn, alarmHeld_ff[3:2], commUnlocked,
		lockoutOn, holdOn, menu_ff};
	wire [31:0] rdMux =
		(regAddr == mcl_pkg::OFS_CTRL) ? {28'h0, ctrl_ff} :
		(regAddr == mcl_pkg::OFS_LOCK4) ? {27'h0, lockByteFour_ff} :
		(regAddr == mcl_pkg::OFS_SERCFG) ? serCfg :
		(regAddr == mcl_pkg::OFS_ADDR) ? {24'h0, busAddress_ff} :
		(regAddr == mcl_pkg::OFS_SP1) ? 32'(limit_ff[0]) :
		(regAddr == mcl_pkg::OFS_SP2) ? 32'(limit_ff[1]) :
		(regAddr == mcl_pkg::OFS_AL1) ? 32'(limit_ff[2]) :
		(regAddr == mcl_pkg::OFS_AL2) ? 32'(limit_ff[3]) :
		(regAddr == mcl_pkg::OFS_DISPLAY) ? 32'(display_ff) :
		(regAddr == mcl_pkg::OFS_PEAK) ? 32'(highestReading_ff) :
		(regAddr == mcl_pkg::OFS_VALLEY) ? 32'(lowestReading_ff) :
		(regAddr == mcl_pkg::OFS_STATUS) ? status :
		(regAddr == mcl_pkg::OFS_SERDATA) ? {23'h0, rxValid_ff, rxHold_ff} :
		(regAddr == mcl_pkg::OFS_TARE) ? 32'(tare_ff) : 32'h0;

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			rd_ff <= 32'h0;
		else if (regRdStb)
			rd_ff <= rdMux;
		else
			rd_ff <= 32'h0;
	end

	assign regRdData = rd_ff;
	assign switchPinOe = swOn_ff;
	assign switchPinOut = 4'h0;
	assign displayValue = display_ff;
	assign displayFlash = flash_ff;
	assign hardResetIndication = hardInd_ff;

endmodule : mcl_control_lines

// *** verif/mcl_control_lines_properties.sv ***
// ==========================================================
// port checker for the control lines
module mcl_control_lines_checker #(
	parameter int DEBOUNCE_CYCLES = 4,
	parameter int RW = 20
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic peakInN,
	input wire logic valleyInN,
	input wire logic resetInN,
	input wire logic holdInN,
	input wire logic serialTx,
	input wire logic [3:0] switchPinOut,
	input wire logic signed [RW-1:0] displayValue,
	input wire logic displayFlash,
	input wire logic hardResetIndication
);
	localparam int HOLD_MIN = DEBOUNCE_CYCLES + 6;
	logic [7:0] holdCnt_ff;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	// ==========================================================
	// cycles the hold contact has stayed low
	always_ff @(posedge ref_clk or negedge resetn)
		if (!resetn)
			holdCnt_ff <= 8'h00;
		else if (holdInN)
			holdCnt_ff <= 8'h00;
		else if (holdCnt_ff != 8'hff)
			holdCnt_ff <= holdCnt_ff + 8'h01;

	// ==========================================================
	// assertions
	pins_od_a:
		assert property (switchPinOut == 4'h0)
		else $error("switch pin driven high");
	flash_cause_a:
		assert property ($rose(displayFlash) |-> !peakInN || !valleyInN)
		else $error("flash without recall contact");
	flash_drop_a:
		assert property ($fell(displayFlash) |-> peakInN && valleyInN)
		else $error("flash dropped during recall");
	bounce_wait_a:
		assert property ($fell(peakInN) && valleyInN && !displayFlash |=> !displayFlash [*3])
		else $error("contact acted before debounce");
	hold_freeze_a:
		assert property (holdCnt_ff > HOLD_MIN |-> $stable(displayValue))
		else $error("display moved during hold");
	reset_pulse_a:
		assert property (hardResetIndication |=> !hardResetIndication)
		else $error("hard reset mark too long");
	reset_cause_a:
		assert property ($rose(hardResetIndication) |-> !resetInN)
		else $error("hard reset without contact");
	start_bit_a:
		assert property ($fell(serialTx) |=> !serialTx [*8])
		else $error("start bit too short");
endmodule : mcl_control_lines_checker

bind mcl_control_lines mcl_control_lines_checker #(
	.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
	.RW(RW)
) i_mcl_control_lines_checker (
	.ref_clk, .resetn, .peakInN, .valleyInN, .resetInN, .holdInN, .serialTx,
	.switchPinOut, .displayValue, .displayFlash, .hardResetIndication
);

// *** verif/mcl_far_side.sv ***
// ==========================================================
// contacts to digital return and host serial port
module mcl_far_side #(
	parameter int DIV = 104
) (
	input wire logic ref_clk,
	input wire logic serialTx,
	output logic serialRx,
	output logic [10:0] lineN
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] rxQ [$];

	initial
	begin
		lineN = 11'h7ff;
		serialRx = 1'b1;
	end

	// ==========================================================
	// contact change with bounce, open lines pulled up
	task automatic press(input int i, input logic lvl);
		repeat (3)
		begin
			@(posedge ref_clk) lineN[i] <= lvl;
			@(posedge ref_clk) lineN[i] <= !lvl;
		end
		@(posedge ref_clk) lineN[i] <= lvl;
		repeat (12) @(posedge ref_clk);
	endtask : press

	// ==========================================================
	// host side, no parity, one stop bit
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int k = 0; k < 10; k++)
			repeat (DIV) @(posedge ref_clk) serialRx <= f[k];
	endtask : send

	always
	begin : host_rx
		logic [7:0] b;
		@(negedge serialTx);
		repeat (DIV / 2) @(posedge ref_clk);
		for (int k = 0; k < 8; k++)
		begin
			repeat (DIV) @(posedge ref_clk);
			b[k] = serialTx;
		end
		repeat (DIV) @(posedge ref_clk);
		rxQ.push_back(b);
	end
endmodule : mcl_far_side

// *** verif/test_meter_control_lines_serial_setup.sv ***
module test_meter_control_lines_serial_setup;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HZ = 1_000_000;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [31:0] regWrData = 32'h0000_0000;
	logic regWrStb = 1'b0;
	logic regRdStb = 1'b0;
	logic readingStb = 1'b0;
	logic signed [19:0] liveReading = 20'sh0_0000;
	logic [31:0] regRdData;
	logic [3:0] switchPinOut, switchPinOe;
	logic signed [19:0] displayValue;
	logic displayFlash, hardResetIndication, serialRx, serialTx;
	logic [10:0] lineN;
	int fails = 0;
	int totalChecks = 0;
	int pulses = 0;

	mcl_control_lines #(
		.CLK_HZ(HZ),
		.DEBOUNCE_CYCLES(4)
	) i_mcl_control_lines (
		.ref_clk, .resetn, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
		.liveReading, .readingStb, .zeroInN(lineN[0]), .peakInN(lineN[1]),
		.valleyInN(lineN[2]), .resetInN(lineN[3]), .holdInN(lineN[4]),
		.lockoutInN(lineN[5]), .printInN(lineN[6]), .menuBtnN(lineN[7]),
		.maxBtnN(lineN[8]), .minBtnN(lineN[9]), .resetBtnN(lineN[10]),
		.serialRx, .serialTx, .switchPinIn(~switchPinOe), .switchPinOut,
		.switchPinOe, .displayValue, .displayFlash, .hardResetIndication
	);
	mcl_far_side #(
		.DIV(HZ / 9600)
	) i_mcl_far_side (
		.ref_clk, .serialTx, .serialRx, .lineN
	);

	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
		if (hardResetIndication === 1'b1)
			pulses++;

	// ==========================================================
	// shared tasks
	task automatic wrap_up();
		if (fails == 0 && totalChecks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge ref_clk);
		regWrStb <= 1'b0;
	endtask : wr
	task automatic rc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge ref_clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge ref_clk);
		regRdStb <= 1'b0;
		#1 cmp(regRdData & m, e);
	endtask : rc
	task automatic sample(input logic signed [19:0] v);
		@(posedge ref_clk);
		liveReading <= v;
		readingStb <= 1'b1;
		@(posedge ref_clk);
		readingStb <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask : sample
	task automatic sw(input int i, input logic lvl);
		i_mcl_far_side.press(i, lvl);
	endtask : sw
	task automatic tap(input int i);
		sw(i, 1'b0);
		sw(i, 1'b1);
	endtask : tap

	// ==========================================================
	// scenarios
	task automatic t_regs();
		rc(mcl_pkg::OFS_CTRL, 32'hf, 32'h0);
		rc(mcl_pkg::OFS_LOCK4, 32'h1f, 32'h1f);
		rc(mcl_pkg::OFS_SERCFG, 32'h3f, 32'h5);
		rc(mcl_pkg::OFS_ADDR, 32'hff, 32'h1);
		rc(4'he, 32'hffff_ffff, 32'h0);
	endtask : t_regs
	task automatic t_lock();
		logic [31:0] v;
		wr(mcl_pkg::OFS_SERCFG, 32'h0000_0036);
		rc(mcl_pkg::OFS_SERCFG, 32'h3f, 32'h5);
		wr(mcl_pkg::OFS_LOCK4, 32'h0000_0010);
		wr(mcl_pkg::OFS_SERCFG, 32'h0000_0036);
		rc(mcl_pkg::OFS_SERCFG, 32'h3f, 32'h5);
		wr(mcl_pkg::OFS_LOCK4, 32'h0000_0000);
		for (int s = 0; s < 2; s++)
			for (int p = 0; p < 3; p++)
			begin
				v = 32'(s * 32 + p * 8 + 5);
				wr(mcl_pkg::OFS_SERCFG, v);
				rc(mcl_pkg::OFS_SERCFG, 32'h3f, v);
			end
		wr(mcl_pkg::OFS_SERCFG, 32'h0000_0005);
		wr(mcl_pkg::OFS_ADDR, 32'h0000_0007);
		rc(mcl_pkg::OFS_ADDR, 32'hff, 32'h7);
	endtask : t_lock
	task automatic t_lockout();
		sw(5, 1'b0);
		rc(mcl_pkg::OFS_STATUS, 32'h10, 32'h10);
		wr(mcl_pkg::OFS_CTRL, 32'h0000_0002);
		wr(mcl_pkg::OFS_SERCFG, 32'h0000_0006);
		rc(mcl_pkg::OFS_CTRL, 32'hf, 32'h0);
		rc(mcl_pkg::OFS_SERCFG, 32'h3f, 32'h5);
		tap(7);
		rc(mcl_pkg::OFS_STATUS, 32'h7, 32'h0);
		sw(5, 1'b1);
	endtask : t_lockout
	task automatic t_menu();
		int btn [8] = '{7, 8, 7, 9, 7, 7, 10, 10};
		logic [2:0] st [8] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0};
		for (int k = 0; k < 8; k++)
		begin
			tap(btn[k]);
			rc(mcl_pkg::OFS_STATUS, 32'h7, 32'(st[k]));
		end
		rc(mcl_pkg::OFS_SERCFG, 32'h7, 32'h6);
		wr(mcl_pkg::OFS_SERCFG, 32'h0000_0005);
	endtask : t_menu
	task automatic t_display();
		wr(mcl_pkg::OFS_SP1, 32'h0000_0046);
		sample(20'sh0_0064);
		sample(-20'sh0_0032);
		sample(20'sh0_001e);
		cmp(32'(switchPinOe[0]), 32'h0);
		sw(1, 1'b0);
		cmp({31'h0, displayFlash}, 32'h1);
		cmp(32'(displayValue), 32'h0000_0064);
		sw(1, 1'b1);
		cmp(32'(displayValue), 32'h0000_001e);
		sw(2, 1'b0);
		cmp(32'(displayValue), 32'hffff_ffce);
		cmp({31'h0, displayFlash}, 32'h1);
		sw(2, 1'b1);
		sw(4, 1'b0);
		sample(20'sh0_0078);
		cmp(32'(displayValue), 32'h0000_001e);
		cmp(32'(switchPinOe[0]), 32'h1);
		rc(mcl_pkg::OFS_PEAK, 32'h000f_ffff, 32'h0000_0078);
		sw(4, 1'b1);
		sample(20'sh0_004d);
		cmp(32'(displayValue), 32'h0000_004d);
	endtask : t_display
	task automatic t_reset();
		wr(mcl_pkg::OFS_CTRL, 32'h0000_0001);
		tap(3);
		cmp(32'(pulses), 32'h0);
		sample(20'sh0_0005);
		rc(mcl_pkg::OFS_PEAK, 32'h000f_ffff, 32'h0000_0005);
		tap(0);
		sample(20'sh0_0005);
		cmp(32'(displayValue), 32'h0);
		wr(mcl_pkg::OFS_CTRL, 32'h0000_0000);
		tap(3);
		cmp(32'(pulses), 32'h1);
		sample(20'sh0_0028);
		cmp(32'(displayValue), 32'h0000_0028);
	endtask : t_reset
	task automatic t_print();
		logic [7:0] exp [7] = '{8'h30, 8'h30, 8'h30, 8'h30, 8'h41, mcl_pkg::CHAR_CR, 8'h5a};
		wr(mcl_pkg::OFS_CTRL, 32'h0000_000e);
		wr(mcl_pkg::OFS_AL1, 32'h0000_0032);
		sample(20'sh0_003c);
		cmp(32'(switchPinOe[2]), 32'h1);
		sample(20'sh0_000a);
		cmp(32'(switchPinOe[2]), 32'h1);
		tap(6);
		sample(20'sh0_000a);
		cmp(32'(switchPinOe[2]), 32'h0);
		wr(mcl_pkg::OFS_SERDATA, 32'h0000_005a);
		for (int k = 0; k < 9000 && i_mcl_far_side.rxQ.size() < 7; k++)
			@(posedge ref_clk);
		if (i_mcl_far_side.rxQ.size() < 7)
		begin
			fails++;
			$display("CHECK FAILED %0t serial output timed out", $time);
			wrap_up();
		end
		foreach (exp[k])
			cmp(32'(i_mcl_far_side.rxQ[k]), 32'(exp[k]));
		i_mcl_far_side.send(8'ha5);
		rc(mcl_pkg::OFS_SERDATA, 32'h1ff, 32'h1a5);
	endtask : t_print

	initial
	begin
		repeat (20) @(posedge ref_clk);
		resetn <= 1'b1;
		t_regs();
		t_lock();
		t_lockout();
		t_menu();
		t_display();
		t_reset();
		t_print();
		wrap_up();
	end
endmodule : test_meter_control_lines_serial_setup
